// ### pkg/sbcr_pkg.sv
// sbcr_pkg: constants and types of the secondary bus clock, reset and arbiter select block
// assumes a 100 MHz core clock and a 160 ns secondary bus clock
package sbcr_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS      = 10;
	localparam int SEC_CLK_PERIOD_NS  = 160;
	localparam int FANOUT_HALF_CYCLES = SEC_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int DIV_W              = 4;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(FANOUT_HALF_CYCLES - 1);
	localparam logic [DIV_W-1:0] DIV_ZERO = 4'h0;

	// ----------------------------------------------------------------
	// clock fanout
	// ----------------------------------------------------------------
	localparam int FANOUT_COUNT = 10;

	// ----------------------------------------------------------------
	// configuration space
	// ----------------------------------------------------------------
	localparam int CFG_ADDR_W = 8;
	localparam int CFG_DATA_W = 32;
	localparam int CFG_BE_W   = 4;
	localparam logic [7:0]  BRIDGE_CTRL_OFFSET = 8'h3E;
	localparam logic [5:0]  BRIDGE_CTRL_DWORD  = BRIDGE_CTRL_OFFSET[7:2];
	localparam int          BRIDGE_CTRL_W      = 16;
	localparam int          BRIDGE_CTRL_LO_BIT = 16;
	localparam int          BRIDGE_CTRL_BE_LO  = 2;
	localparam int          SEC_RESET_BIT      = 6;
	localparam logic [15:0] BRIDGE_CTRL_RESET  = 16'h0000;
	localparam logic [31:0] CFG_READ_ZERO      = 32'h0000_0000;

	// ----------------------------------------------------------------
	// internal arbiter states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SBCR_ARB_IDLE   = 2'b00,
		SBCR_ARB_BRIDGE = 2'b01,
		SBCR_ARB_AGENT  = 2'b10
	} sbcr_arb_state_t;

endpackage : sbcr_pkg

// ### hw/sbcr_sec_arb.sv
// sbcr_sec_arb: secondary bus arbitration for request/grant pair zero
// assumes all inputs already in the secondary clock domain, pins sampled here
`timescale 1ns/1ps
module sbcr_sec_arb (
	// secondary clock and reset
	input  wire logic sec_clk_in,
	input  wire logic sec_rst_in,
	// mode and bridge master
	input  wire logic ext_sel_in,
	input  wire logic bridge_req_in,
	output logic      bridge_gnt_out,
	// pins, active low
	input  wire logic sec_request_zero_n_in,
	output logic      sec_grant_zero_n_out
);

	// ----------------------------------------------------------------
	// pin sampling and next state
	// ----------------------------------------------------------------
	logic                     req_pin_q;
	logic                     last_agent_q;
	sbcr_pkg::sbcr_arb_state_t state_q;
	sbcr_pkg::sbcr_arb_state_t state_d;

	wire agent_req  = req_pin_q;
	wire agent_wins = agent_req && (!bridge_req_in || !last_agent_q);

	always_comb begin
		state_d = state_q;
		case (state_q)
			sbcr_pkg::SBCR_ARB_IDLE: begin
				if (agent_wins)
					state_d = sbcr_pkg::SBCR_ARB_AGENT;
				else if (bridge_req_in)
					state_d = sbcr_pkg::SBCR_ARB_BRIDGE;
			end
			sbcr_pkg::SBCR_ARB_AGENT: begin
				if (!agent_req)
					state_d = sbcr_pkg::SBCR_ARB_IDLE;
			end
			sbcr_pkg::SBCR_ARB_BRIDGE: begin
				if (!bridge_req_in)
					state_d = sbcr_pkg::SBCR_ARB_IDLE;
			end
			default: state_d = sbcr_pkg::SBCR_ARB_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// pin roles follow the arbiter select
	// ----------------------------------------------------------------
	// external: grant-zero carries our request, request-zero our grant
	wire gnt_pin_d    = ext_sel_in ? !bridge_req_in : (state_d != sbcr_pkg::SBCR_ARB_AGENT);
	wire bridge_gnt_d = ext_sel_in ? agent_req : (state_d == sbcr_pkg::SBCR_ARB_BRIDGE);

	always_ff @(posedge sec_clk_in) begin
		if (sec_rst_in) begin
			req_pin_q            <= 1'b0;
			state_q              <= sbcr_pkg::SBCR_ARB_IDLE;
			last_agent_q         <= 1'b0;
			sec_grant_zero_n_out <= 1'b1;
			bridge_gnt_out       <= 1'b0;
		end else begin
			req_pin_q            <= !sec_request_zero_n_in;
			state_q              <= ext_sel_in ? sbcr_pkg::SBCR_ARB_IDLE : state_d;
			if (state_d == sbcr_pkg::SBCR_ARB_AGENT)
				last_agent_q <= 1'b1;
			else if (state_d == sbcr_pkg::SBCR_ARB_BRIDGE)
				last_agent_q <= 1'b0;
			sec_grant_zero_n_out <= gnt_pin_d;
			bridge_gnt_out       <= bridge_gnt_d;
		end
	end

endmodule : sbcr_sec_arb

// ### hw/sbcr_top.sv
// sbcr_top: secondary clock fanout, secondary reset, arbiter select
// assumes a primary configuration port on clk_in and a free running secondary clock input
//
// Notes on behaviour
// - drive ten secondary clocks; agents sample on them
// - secondary interface logic runs on secondary clock
// - select high means external arbiter does arbitration
// - external mode: request-zero is grant, grant-zero request
// - secondary reset when primary reset or control bit
// - secondary reset is combinational, not clock synchronised
// - configuration access only from primary bus
`timescale 1ns/1ps
module sbcr_top (
	// core clock, reset, enable
	input  wire logic                                clk_in,
	input  wire logic                                rst_in,
	input  wire logic                                ce_in,
	// primary reset pin, active low
	input  wire logic                                prim_reset_n_in,
	// primary configuration port
	input  wire logic                                cfg_sel_in,
	input  wire logic                                cfg_we_in,
	input  wire logic [sbcr_pkg::CFG_ADDR_W-1:0]     cfg_addr_in,
	input  wire logic [sbcr_pkg::CFG_BE_W-1:0]       cfg_be_in,
	input  wire logic [sbcr_pkg::CFG_DATA_W-1:0]     cfg_wdata_in,
	output logic      [sbcr_pkg::CFG_DATA_W-1:0]     cfg_rdata_out,
	output logic                                     cfg_ack_out,
	// bridge master request and grant
	input  wire logic                                bridge_req_in,
	output logic                                     bridge_gnt_out,
	// secondary clocks
	output logic      [sbcr_pkg::FANOUT_COUNT-1:0]   sec_clock_fanout_out,
	input  wire logic                                sec_clk_in,
	// secondary reset, active low
	output logic                                     sec_reset_n_out,
	// secondary arbitration pins
	input  wire logic                                ext_arbiter_select_in,
	input  wire logic                                sec_request_zero_n_in,
	output logic                                     sec_grant_zero_n_out
);

	// ----------------------------------------------------------------
	// primary reset pin synchroniser
	// ----------------------------------------------------------------
	logic prim_rst_meta_q;
	logic prim_rst_sync_q;

	always_ff @(posedge clk_in) begin
		if (ce_in) begin
			prim_rst_meta_q <= !prim_reset_n_in;
			prim_rst_sync_q <= prim_rst_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// configuration decode
	// ----------------------------------------------------------------
	logic [sbcr_pkg::BRIDGE_CTRL_W-1:0] bridge_control_q;
	logic [sbcr_pkg::BRIDGE_CTRL_W-1:0] bridge_control_d;
	logic [sbcr_pkg::CFG_DATA_W-1:0]    cfg_rdata_d;

	// only the primary port reaches configuration space
	wire ctrl_hit = cfg_sel_in && (cfg_addr_in[7:2] == sbcr_pkg::BRIDGE_CTRL_DWORD);
	wire ctrl_wr  = ctrl_hit && cfg_we_in;
	wire [sbcr_pkg::BRIDGE_CTRL_W-1:0] ctrl_wdata =
		cfg_wdata_in[sbcr_pkg::BRIDGE_CTRL_LO_BIT +: sbcr_pkg::BRIDGE_CTRL_W];
	wire [1:0] ctrl_be = cfg_be_in[sbcr_pkg::BRIDGE_CTRL_BE_LO +: 2];

	always_comb begin
		bridge_control_d = bridge_control_q;
		if (ctrl_wr && ctrl_be[0])
			bridge_control_d[7:0] = ctrl_wdata[7:0];
		if (ctrl_wr && ctrl_be[1])
			bridge_control_d[15:8] = ctrl_wdata[15:8];
	end

	always_comb begin
		cfg_rdata_d = sbcr_pkg::CFG_READ_ZERO;
		if (ctrl_hit && !cfg_we_in)
			cfg_rdata_d[sbcr_pkg::BRIDGE_CTRL_LO_BIT +: sbcr_pkg::BRIDGE_CTRL_W] = bridge_control_q;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in || (ce_in && prim_rst_sync_q)) begin
			bridge_control_q <= sbcr_pkg::BRIDGE_CTRL_RESET;
			cfg_rdata_out    <= sbcr_pkg::CFG_READ_ZERO;
			cfg_ack_out      <= 1'b0;
		end else if (ce_in) begin
			bridge_control_q <= bridge_control_d;
			cfg_rdata_out    <= cfg_rdata_d;
			cfg_ack_out      <= cfg_sel_in;
		end
	end

	// ----------------------------------------------------------------
	// secondary reset output
	// ----------------------------------------------------------------
	// plain gate: edges are free of the secondary clock
	wire sec_reset_bit = bridge_control_q[sbcr_pkg::SEC_RESET_BIT];
	assign sec_reset_n_out = prim_reset_n_in && !sec_reset_bit;

	// ----------------------------------------------------------------
	// secondary clock fanout
	// ----------------------------------------------------------------
	logic [sbcr_pkg::DIV_W-1:0] div_cnt_q;
	logic                       div_phase_q;

	wire div_wrap = (div_cnt_q == sbcr_pkg::DIV_LAST);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			div_cnt_q   <= sbcr_pkg::DIV_ZERO;
			div_phase_q <= 1'b0;
		end else if (ce_in) begin
			div_cnt_q   <= div_wrap ? sbcr_pkg::DIV_ZERO : div_cnt_q + 1'b1;
			div_phase_q <= div_wrap ? !div_phase_q : div_phase_q;
		end
	end

	// one flop per output keeps skew between agents equal
	genvar g;
	generate
		for (g = 0; g < sbcr_pkg::FANOUT_COUNT; g++) begin : g_fanout
			always_ff @(posedge clk_in) begin
				if (rst_in)
					sec_clock_fanout_out[g] <= 1'b0;
				else if (ce_in)
					sec_clock_fanout_out[g] <= div_phase_q;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// core side levels toward the secondary domain
	// ----------------------------------------------------------------
	// hold stays up until the secondary domain echoes it back,
	// so a core reset shorter than a secondary period is not lost
	logic sec_hold_q;
	logic bridge_req_q;
	logic rst_pend_q;
	logic rst_echo_meta_q;
	logic rst_echo_q;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sec_hold_q   <= 1'b1;
			bridge_req_q <= 1'b0;
			rst_pend_q   <= 1'b1;
		end else if (ce_in) begin
			sec_hold_q   <= prim_rst_sync_q || sec_reset_bit || rst_pend_q;
			bridge_req_q <= bridge_req_in;
			if (rst_echo_q)
				rst_pend_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// secondary domain synchronisers
	// ----------------------------------------------------------------
	logic sec_rst_meta_q;
	logic sec_rst_q;
	logic sel_meta_q;
	logic sel_q;
	logic req_meta_q;
	logic req_q;

	always_ff @(posedge sec_clk_in) begin
		sec_rst_meta_q <= sec_hold_q;
		sec_rst_q      <= sec_rst_meta_q;
		sel_meta_q     <= ext_arbiter_select_in;
		sel_q          <= sel_meta_q;
		req_meta_q     <= bridge_req_q;
		req_q          <= req_meta_q;
	end

	// ----------------------------------------------------------------
	// secondary hold echoed back to the core clock
	// ----------------------------------------------------------------
	// two flops: sec_rst_q is a secondary clock level
	// pending core reset clears only once the echo is seen
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rst_echo_meta_q <= 1'b0;
			rst_echo_q      <= 1'b0;
		end else if (ce_in) begin
			rst_echo_meta_q <= sec_rst_q;
			rst_echo_q      <= rst_echo_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// arbitration on the secondary clock
	// ----------------------------------------------------------------
	logic sec_bridge_gnt;

	sbcr_sec_arb u_arb (
		.sec_clk_in            (sec_clk_in),
		.sec_rst_in            (sec_rst_q),
		.ext_sel_in            (sel_q),
		.bridge_req_in         (req_q),
		.bridge_gnt_out        (sec_bridge_gnt),
		.sec_request_zero_n_in (sec_request_zero_n_in),
		.sec_grant_zero_n_out  (sec_grant_zero_n_out)
	);

	// ----------------------------------------------------------------
	// grant back to the core clock
	// ----------------------------------------------------------------
	logic gnt_meta_q;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			gnt_meta_q     <= 1'b0;
			bridge_gnt_out <= 1'b0;
		end else if (ce_in) begin
			gnt_meta_q     <= sec_bridge_gnt;
			bridge_gnt_out <= gnt_meta_q;
		end
	end

endmodule : sbcr_top

// ### testbench/sbcr_top_assertions.sv
// sbcr_top_chk: port checks bound onto sbcr_top
// assumes a running secondary clock; ce_in may go low, ce_hold_a checks the freeze
`timescale 1ns/1ps
module sbcr_top_chk (
	// watched ports
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic        ce_in,
	input wire logic        prim_reset_n_in,
	input wire logic        cfg_sel_in,
	input wire logic        cfg_we_in,
	input wire logic [7:0]  cfg_addr_in,
	input wire logic [3:0]  cfg_be_in,
	input wire logic [31:0] cfg_wdata_in,
	input wire logic        cfg_ack_out,
	input wire logic [9:0]  sec_clock_fanout_out,
	input wire logic        sec_reset_n_out,
	input wire logic        sec_clk_in,
	input wire logic        ext_arbiter_select_in,
	input wire logic        bridge_req_in,
	input wire logic        bridge_gnt_out,
	input wire logic        sec_request_zero_n_in,
	input wire logic        sec_grant_zero_n_out
);
	wire ctl_wr = ce_in && cfg_sel_in && cfg_we_in && cfg_addr_in[7:2] == 6'h0F && cfg_be_in[2];
	wire fo = sec_clock_fanout_out[0];
	// ----------
	// arbitration steps
	// ----------
	sequence agent_only;
		(!ext_arbiter_select_in && !sec_request_zero_n_in && !bridge_req_in && sec_reset_n_out)[*8];
	endsequence
	sequence ext_asked;
		(ext_arbiter_select_in && bridge_req_in && sec_reset_n_out)[*8];
	endsequence
	ack_pair_a: assert property (@(posedge clk_in) disable iff (rst_in) $past(ce_in) |-> cfg_ack_out == $past(cfg_sel_in))
		else $error("ack mismatch");
	ce_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
		!ce_in |=> $stable({sec_clock_fanout_out, cfg_ack_out, bridge_gnt_out})) else $error("enable freeze");
	rst_prim_a: assert property (@(posedge clk_in) disable iff (rst_in) !prim_reset_n_in |-> !sec_reset_n_out)
		else $error("reset not passed");
	rst_bit_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ctl_wr |=> sec_reset_n_out == (!$past(cfg_wdata_in[22]) && prim_reset_n_in)) else $error("reset bit");
	fan_same_a: assert property (@(posedge clk_in) disable iff (rst_in) sec_clock_fanout_out == {10{fo}})
		else $error("fanout differs");
	fan_half_a: assert property (@(posedge clk_in) disable iff (rst_in || !ce_in) $rose(fo) |-> fo[*8] ##1 !fo)
		else $error("fanout period");
	int_grant_a: assert property (@(posedge sec_clk_in) disable iff (rst_in) agent_only |-> !sec_grant_zero_n_out)
		else $error("agent not granted");
	ext_req_a: assert property (@(posedge sec_clk_in) disable iff (rst_in) ext_asked |-> !sec_grant_zero_n_out)
		else $error("no external request");
	ext_gnt_a: assert property (@(posedge sec_clk_in) disable iff (rst_in)
		ext_asked ##0 (!sec_request_zero_n_in)[*4] |-> bridge_gnt_out) else $error("external grant lost");
endmodule : sbcr_top_chk
bind sbcr_top sbcr_top_chk u_chk (.*);

// ### testbench/sbcr_far_model.sv
// sbcr_far_model: agent zero, or external arbiter when selected
// assumes the bench's secondary clock
`timescale 1ns/1ps
module sbcr_far_model (
	// clock, mode, demand
	input  wire logic       sec_clk_in,
	input  wire logic       ext_sel_in,
	input  wire logic       want_in,
	input  wire logic [2:0] lag_in,
	// pins, active low
	input  wire logic       grant_zero_n_in,
	output logic            request_zero_n_out = 1'b1
);
	logic [2:0] wait_q = 3'h0;
	always @(posedge sec_clk_in) begin
		if (!ext_sel_in || grant_zero_n_in) begin
			request_zero_n_out <= !(want_in && !ext_sel_in);
			wait_q <= 3'h0;
		end else if (wait_q >= lag_in) begin
			request_zero_n_out <= 1'b0;
		end else begin
			wait_q <= wait_q + 3'h1;
		end
	end
endmodule : sbcr_far_model

// ### testbench/tb.sv
// tb: random and corner checks of sbcr_top
// assumes the bound checker and sbcr_far_model
`timescale 1ns/1ps
module tb;
	// ----------
	// ports and bench state
	// ----------
	logic        clk_in = 1'b0;
	logic        sec_clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        prim_reset_n_in = 1'b1;
	logic        cfg_sel_in = 1'b0;
	logic        cfg_we_in = 1'b0;
	logic [7:0]  cfg_addr_in = 8'h00;
	logic [3:0]  cfg_be_in = 4'h0;
	logic [31:0] cfg_wdata_in = 32'h0;
	logic [31:0] cfg_rdata_out;
	logic [9:0]  sec_clock_fanout_out;
	logic        cfg_ack_out, bridge_gnt_out, sec_reset_n_out, sec_request_zero_n_in, sec_grant_zero_n_out;
	logic        bridge_req_in = 1'b0;
	logic        ext_arbiter_select_in = 1'b0;
	logic        want = 1'b0;
	logic        ce_in = 1'b1;
	logic [9:0]  held;
	logic [2:0]  lag = 3'h0;
	logic [31:0] seed = 32'h69DEBA7C;
	logic [15:0] ctrl = 16'h0;
	int          failures = 0;
	int          n_checks = 0;
	int          cycles = 0;
	sbcr_top uut (
		.clk_in                (clk_in),
		.rst_in                (rst_in),
		.ce_in                 (ce_in),
		.prim_reset_n_in       (prim_reset_n_in),
		.cfg_sel_in            (cfg_sel_in),
		.cfg_we_in             (cfg_we_in),
		.cfg_addr_in           (cfg_addr_in),
		.cfg_be_in             (cfg_be_in),
		.cfg_wdata_in          (cfg_wdata_in),
		.cfg_rdata_out         (cfg_rdata_out),
		.cfg_ack_out           (cfg_ack_out),
		.bridge_req_in         (bridge_req_in),
		.bridge_gnt_out        (bridge_gnt_out),
		.sec_clock_fanout_out  (sec_clock_fanout_out),
		.sec_clk_in            (sec_clk_in),
		.sec_reset_n_out       (sec_reset_n_out),
		.ext_arbiter_select_in (ext_arbiter_select_in),
		.sec_request_zero_n_in (sec_request_zero_n_in),
		.sec_grant_zero_n_out  (sec_grant_zero_n_out)
	);
	sbcr_far_model far (
		.sec_clk_in        (sec_clk_in),
		.ext_sel_in        (ext_arbiter_select_in),
		.want_in           (want),
		.lag_in            (lag),
		.grant_zero_n_in   (sec_grant_zero_n_out),
		.request_zero_n_out(sec_request_zero_n_in)
	);
	always #5 clk_in = ~clk_in;
	initial #37 forever #80 sec_clk_in = ~sec_clk_in;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [15:0] merge(input logic [15:0] c, input logic [3:0] b, input logic [31:0] d);
		return {b[3] ? d[31:24] : c[15:8], b[2] ? d[23:16] : c[7:0]};
	endfunction : merge
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : tick
	task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		tick(1);
		cfg_sel_in = 1'b1;
		cfg_we_in = w;
		cfg_addr_in = a;
		cfg_be_in = b;
		cfg_wdata_in = d;
		tick(1);
		cfg_sel_in = 1'b0;
		chk({31'h0, cfg_ack_out}, 32'h1);
		chk(cfg_rdata_out, (!w && a[7:2] == 6'h0F) ? {ctrl, 16'h0} : 32'h0);
		if (w && a[7:2] == 6'h0F) ctrl = merge(ctrl, b, d);
	endtask : cfg
	task automatic await(input logic gnt, input logic lvl);
		for (int k = 0; k < 300; k++) begin
			if ((gnt ? bridge_gnt_out : sec_grant_zero_n_out) === lvl) break;
			tick(1);
		end
		chk({31'h0, gnt ? bridge_gnt_out : sec_grant_zero_n_out}, {31'h0, lvl});
	endtask : await
	task automatic close_out();
		if (failures == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			close_out();
		end
	end
	initial begin
		tick(4);
		rst_in = 1'b0;
		cfg(1'b0, 8'h3C, 4'h0, 32'h0);
		for (int i = 0; i < 40; i++) begin
			seed = lfsr(seed);
			cfg(seed[0], seed[1] ? 8'h3C : seed[15:8], seed[19:16], seed);
			chk({31'h0, sec_reset_n_out}, {31'h0, !ctrl[6]});
			cfg(1'b0, 8'h3E, 4'h0, 32'h0);
		end
		cfg(1'b1, 8'h3C, 4'hC, 32'h1234_0000);
		prim_reset_n_in = 1'b0;
		#1 chk({31'h0, sec_reset_n_out}, 32'h0);
		tick(4);
		prim_reset_n_in = 1'b1;
		ctrl = 16'h0;
		tick(4);
		cfg(1'b0, 8'h3C, 4'h0, 32'h0);
		chk({31'h0, sec_reset_n_out}, 32'h1);
		tick(1);
		ce_in = 1'b0;
		held = sec_clock_fanout_out;
		cfg_sel_in = 1'b1;
		cfg_we_in = 1'b1;
		cfg_addr_in = 8'h3C;
		cfg_be_in = 4'hC;
		cfg_wdata_in = 32'hFFFF_0000;
		tick(1);
		cfg_sel_in = 1'b0;
		tick(20);
		chk({22'h0, sec_clock_fanout_out}, {22'h0, held});
		chk({31'h0, cfg_ack_out}, 32'h0);
		chk({31'h0, sec_reset_n_out}, 32'h1);
		ce_in = 1'b1;
		cfg(1'b0, 8'h3C, 4'h0, 32'h0);
		tick(100);
		want = 1'b1;
		await(1'b0, 1'b0);
		tick(160);
		chk({31'h0, sec_grant_zero_n_out}, 32'h0);
		bridge_req_in = 1'b1;
		tick(100);
		chk({31'h0, bridge_gnt_out}, 32'h0);
		want = 1'b0;
		await(1'b1, 1'b1);
		bridge_req_in = 1'b0;
		await(1'b0, 1'b1);
		await(1'b1, 1'b0);
		tick(20);
		ext_arbiter_select_in = 1'b1;
		for (int j = 0; j < 2; j++) begin
			seed = lfsr(seed);
			lag = j ? seed[2:0] : 3'h0;
			bridge_req_in = 1'b1;
			await(1'b0, 1'b0);
			await(1'b1, 1'b1);
			tick(160);
			chk({31'h0, sec_grant_zero_n_out}, 32'h0);
			chk({31'h0, bridge_gnt_out}, 32'h1);
			bridge_req_in = 1'b0;
			await(1'b0, 1'b1);
			await(1'b1, 1'b0);
		end
		close_out();
	end
endmodule : tb
